// *** hdl/external_memory_bus_interface.sv ***
`timescale 1ns/1ps
// Functional notes
// - Low address and data share port
// - High address byte on separate port
// - Active-high address latch strobe output
// - Latch strobe every six oscillator periods
// - One latch strobe skipped per data access
// - Latch strobe released during reset
// - Fetch strobe low for fetch, table reads
// - Fetch strobe released during reset
// - Force pin low makes all fetches external
// - Separate write and read data strobes
// - Separate 64K code and data spaces
// - Oscillator divided by two internally
// - Static logic survives a stopped clock
// - Port latches reset to all ones
module external_memory_bus_interface (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire ext_bus_pkg::bus_req_t req_in,
    output logic req_ready_out,
    output ext_bus_pkg::bus_rsp_t rsp_out,
    input wire logic external_fetch_force_n_in,
    input wire logic [7:0] low_addr_data_port_in,
    output logic [7:0] low_addr_data_port_out,
    output logic low_addr_data_port_oe_out,
    output logic [7:0] high_addr_port_out,
    output logic addr_latch_strobe_out,
    output logic addr_latch_strobe_oe_out,
    output logic program_fetch_strobe_n_out,
    output logic program_fetch_strobe_n_oe_out,
    output logic data_write_strobe_n_out,
    output logic data_read_strobe_n_out
);
    import ext_bus_pkg::*;

    // static state only
    // Sequencing state; all of it is plain flops, so a stopped
    // oscillator simply freezes the bus where it stands.
    logic phase;
    logic [1:0] st;
    mode_t mode;
    acc_kind_t kind;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic int_code;

    logic force_meta;
    logic force_sync;
    logic [7:0] port_meta;
    logic [7:0] port_sync;

    // Output flops
    logic ale;
    logic ale_oe;
    logic program_fetch_strobe_n_n;
    logic program_fetch_strobe_n_oe;
    logic rd_n;
    logic wr_n;
    logic [7:0] low_out;
    logic low_oe;
    logic [7:0] high_out;
    logic done;
    logic internal_ack;
    logic [7:0] rdata;

    // A slot is six ticks: latch strobe on ticks 0-1, low address on
    // ticks 0-2, fetch or data strobe on ticks 3-5. A data access adds
    // a second slot with no latch strobe, its strobe ending at tick 4.
    // Current position
    wire [2:0] tick = {st, phase};
    wire slot_end = (st == STATE_LAST) && phase;
    wire is_code_kind = (req_in.kind == ACC_FETCH) ||
        (req_in.kind == ACC_CODE_TABLE);

    // the slot after the address slot of a data access is busy
    assign req_ready_out = slot_end && (mode != M_DADDR);
    wire take = req_in.valid && req_ready_out;

    // below the on-chip limit a fetch stays inside unless forced
    wire req_internal = force_sync && is_code_kind &&
        (req_in.addr <= INT_ROM_TOP);

    // each internal state spans two oscillator periods
    wire next_phase = ~phase;
    wire [1:0] st_inc = (st == STATE_LAST) ? STATE_FIRST : st + 2'h1;
    wire [1:0] next_st = phase ? st_inc : st;
    wire [2:0] next_tick = {next_st, next_phase};

    mode_t next_mode;
    always_comb begin
        next_mode = mode;
        case (mode)
            M_IDLE: begin
                if (take && is_code_kind) begin
                    next_mode = M_CODE;
                end else if (take) begin
                    next_mode = M_DADDR;
                end
            end
            // a data access holds the bus for two slots
            M_DADDR: begin
                if (slot_end) begin
                    next_mode = M_DXFER;
                end
            end
            M_CODE, M_DXFER: begin
                if (take && is_code_kind) begin
                    next_mode = M_CODE;
                end else if (take) begin
                    next_mode = M_DADDR;
                end else if (slot_end) begin
                    next_mode = M_IDLE;
                end
            end
            default: begin
                next_mode = M_IDLE;
            end
        endcase
    end

    wire acc_kind_t next_kind = take ? req_in.kind : kind;
    wire [15:0] next_addr = take ? req_in.addr : addr;
    wire [7:0] next_wdata = take ? req_in.wdata : wdata;
    wire next_int = take ? req_internal : int_code;

    wire next_ext_code = (next_mode == M_CODE) && !next_int;
    wire next_ext_any = next_ext_code || (next_mode == M_DADDR) ||
        (next_mode == M_DXFER);

    // strobe high over the first two of the three ticks the low address stands
    // latch strobe in the first state of every slot, idle or not
    // but never in the transfer slot of a data access
    wire next_ale = (next_mode != M_DXFER) &&
        (next_tick <= ALE_LAST_TICK);

    // address held one tick past the strobe's fall
    wire next_addr_drive = (next_ext_code || (next_mode == M_DADDR)) &&
        (next_tick <= ADDR_LAST_TICK);

    // fetch strobe after the address phase of an external fetch
    wire next_program_fetch_strobe_n_n = !(next_ext_code && (next_tick > ADDR_LAST_TICK));

    // read and write strobes run from tick 3 of the address slot to tick 4 of the transfer slot
    wire next_data_strobe =
        ((next_mode == M_DADDR) && (next_tick > ADDR_LAST_TICK)) ||
        ((next_mode == M_DXFER) && (next_tick < TICK_LAST));
    wire next_rd_n = !(next_data_strobe && (next_kind == ACC_DATA_READ));
    wire next_wr_n = !(next_data_strobe && (next_kind == ACC_DATA_WRITE));

    // write data stays one tick past the rising write strobe
    wire next_wdrive = (next_kind == ACC_DATA_WRITE) &&
        (((next_mode == M_DADDR) && (next_tick > ADDR_LAST_TICK)) ||
        (next_mode == M_DXFER));

    // one port carries the address, then the data
    wire [7:0] next_low_out = next_addr_drive ? next_addr[7:0] :
        (next_wdrive ? next_wdata : PORT_RESET);
    wire next_low_oe = next_addr_drive || next_wdrive;

    // high byte stands for the whole external access
    // one 16-bit address for either space, strobe tells them apart
    wire [7:0] next_high_out = next_ext_any ? next_addr[15:8] :
        PORT_RESET;

    // Data is taken from the synchronised port on the strobe's last tick
    wire code_sample = (mode == M_CODE) && (tick == CODE_SAMPLE_TICK);
    wire data_sample = (mode == M_DXFER) && (tick == DATA_SAMPLE_TICK);
    wire next_done = code_sample || data_sample;
    wire rd_capture = (code_sample && !int_code) ||
        (data_sample && (kind == ACC_DATA_READ));
    wire [7:0] next_rdata = rd_capture ? port_sync : rdata;

    // Pins from outside pass two flops before use
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            force_meta <= 1'b0;
            force_sync <= 1'b0;
        end else begin
            force_meta <= external_fetch_force_n_in;
            force_sync <= force_meta;
        end
    end

    // Read data is seen two clocks late, so memory must drive early
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            port_meta <= PORT_RESET;
            port_sync <= PORT_RESET;
        end else begin
            port_meta <= low_addr_data_port_in;
            port_sync <= port_meta;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase <= 1'b0;
            st <= STATE_FIRST;
            mode <= M_IDLE;
        end else begin
            phase <= next_phase;
            st <= next_st;
            mode <= next_mode;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            kind <= ACC_FETCH;
            int_code <= 1'b0;
        end else begin
            kind <= next_kind;
            int_code <= next_int;
        end
    end

    // Address and write data stand for the whole access
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            addr <= 16'h0000;
            wdata <= 8'h00;
        end else begin
            addr <= next_addr;
            wdata <= next_wdata;
        end
    end

    // latch strobe released while reset is held
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ale <= 1'b0;
            ale_oe <= 1'b0;
        end else begin
            ale <= next_ale;
            ale_oe <= 1'b1;
        end
    end

    // fetch strobe released while reset is held
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            program_fetch_strobe_n_n <= 1'b1;
            program_fetch_strobe_n_oe <= 1'b0;
        end else begin
            program_fetch_strobe_n_n <= next_program_fetch_strobe_n_n;
            program_fetch_strobe_n_oe <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_n <= 1'b1;
            wr_n <= 1'b1;
        end else begin
            rd_n <= next_rd_n;
            wr_n <= next_wr_n;
        end
    end

    // port latches at all ones out of reset
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            low_out <= PORT_RESET;
            low_oe <= 1'b0;
            high_out <= PORT_RESET;
        end else begin
            low_out <= next_low_out;
            low_oe <= next_low_oe;
            high_out <= next_high_out;
        end
    end

    // Answer pulses last one cycle
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            done <= 1'b0;
            internal_ack <= 1'b0;
        end else begin
            done <= next_done;
            internal_ack <= code_sample && int_code;
        end
    end

    // Read data holds until the next capture
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign rsp_out = '{done: done, internal: internal_ack, rdata: rdata};
    assign low_addr_data_port_out = low_out;
    assign low_addr_data_port_oe_out = low_oe;
    assign high_addr_port_out = high_out;
    assign addr_latch_strobe_out = ale;
    assign addr_latch_strobe_oe_out = ale_oe;
    assign program_fetch_strobe_n_out = program_fetch_strobe_n_n;
    assign program_fetch_strobe_n_oe_out = program_fetch_strobe_n_oe;
    assign data_write_strobe_n_out = wr_n;
    assign data_read_strobe_n_out = rd_n;

endmodule

// *** common/ext_bus_pkg.sv ***
package ext_bus_pkg;

    // Oscillator input period in ns, the clock of this block
    localparam int OSC_PERIOD_NS = 50;
    // Tick positions within one strobe slot (six oscillator periods)
    localparam logic [2:0] TICK_LAST = 3'h5;
    localparam logic [2:0] ALE_LAST_TICK = 3'h1;
    localparam logic [2:0] ADDR_LAST_TICK = 3'h2;
    localparam logic [2:0] CODE_SAMPLE_TICK = 3'h5;
    localparam logic [2:0] DATA_SAMPLE_TICK = 3'h4;
    localparam logic [1:0] STATE_LAST = 2'h2;
    localparam logic [1:0] STATE_FIRST = 2'h0;
    // Port latches come out of reset at all ones
    localparam logic [7:0] PORT_RESET = 8'hFF;
    // Highest code address served by on-chip program memory
    localparam logic [15:0] INT_ROM_TOP = 16'h0FFF;

    typedef enum logic [1:0] {
        ACC_FETCH = 2'h0,
        ACC_CODE_TABLE = 2'h1,
        ACC_DATA_READ = 2'h2,
        ACC_DATA_WRITE = 2'h3
    } acc_kind_t;

    typedef enum logic [3:0] {
        M_IDLE = 4'h1,
        M_CODE = 4'h2,
        M_DADDR = 4'h4,
        M_DXFER = 4'h8
    } mode_t;

    typedef struct packed {
        logic valid;
        acc_kind_t kind;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic done;
        logic internal;
        logic [7:0] rdata;
    } bus_rsp_t;

endpackage

// *** verif/ext_bus_sva.sv ***
`timescale 1ns/1ps
module ext_bus_sva (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire ext_bus_pkg::bus_rsp_t rsp_out,
    input wire logic low_addr_data_port_oe_out,
    input wire logic addr_latch_strobe_out,
    input wire logic addr_latch_strobe_oe_out,
    input wire logic program_fetch_strobe_n_out,
    input wire logic program_fetch_strobe_n_oe_out,
    input wire logic data_write_strobe_n_out,
    input wire logic data_read_strobe_n_out
);
    import ext_bus_pkg::*;
    logic ale, program_fetch_strobe_n_n, rd_n, wr_n, oe, settled;
    logic [3:0] age;
    assign ale = addr_latch_strobe_out;
    assign program_fetch_strobe_n_n = program_fetch_strobe_n_out;
    assign rd_n = data_read_strobe_n_out;
    assign wr_n = data_write_strobe_n_out;
    assign oe = low_addr_data_port_oe_out;
    // First slot after reset is short, so pacing checks wait
    assign settled = age == 4'hF;
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) age <= 4'h0;
        else if (!settled) age <= age + 4'h1;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    ale_pair_a: assert property (
        settled && $rose(ale) |=> ale ##1 !ale)
        else $error("latch strobe width wrong");
    ale_rate_a: assert property (
        settled && $rose(ale) ##3 (rd_n && wr_n) |-> ##3 ale)
        else $error("latch strobe not every six cycles");
    ale_skip_a: assert property (
        settled && $rose(ale) ##3 !(rd_n && wr_n) |-> ##3 !ale [*6] ##1 ale)
        else $error("latch strobe not skipped once");
    ale_release_a: assert property (
        disable iff (arst_n_in) 1'b1 |-> !addr_latch_strobe_oe_out)
        else $error("latch strobe driven in reset");
    fetch_release_a: assert property (
        disable iff (arst_n_in) 1'b1 |-> !program_fetch_strobe_n_oe_out)
        else $error("fetch strobe driven in reset");
    fetch_pulse_a: assert property (
        $fell(program_fetch_strobe_n_n) |-> (!program_fetch_strobe_n_n) [*3] ##1 program_fetch_strobe_n_n)
        else $error("fetch strobe width wrong");
    fetch_turn_a: assert property (
        $fell(program_fetch_strobe_n_n) |-> $past(oe, 2) && !oe)
        else $error("port not turned after address");
    read_float_a: assert property (
        !rd_n || !program_fetch_strobe_n_n |-> !oe)
        else $error("port driven while memory drives");
    write_drive_a: assert property (
        !wr_n |-> oe)
        else $error("write data not driven");
    read_pulse_a: assert property (
        $fell(rd_n) |-> (!rd_n) [*8] ##1 (rd_n && rsp_out.done))
        else $error("read strobe timing wrong");
    write_pulse_a: assert property (
        $fell(wr_n) |-> (!wr_n) [*8] ##1 (wr_n && rsp_out.done))
        else $error("write strobe timing wrong");
endmodule

bind external_memory_bus_interface ext_bus_sva chk (
    .core_clk_in, .arst_n_in, .rsp_out, .low_addr_data_port_oe_out,
    .addr_latch_strobe_out, .addr_latch_strobe_oe_out,
    .program_fetch_strobe_n_out, .program_fetch_strobe_n_oe_out,
    .data_write_strobe_n_out, .data_read_strobe_n_out);

// *** verif/ext_mem_model.sv ***
`timescale 1ns/1ps
module ext_mem_model (
    input wire logic ale_in,
    input wire logic [7:0] port_in,
    input wire logic [7:0] high_in,
    input wire logic fetch_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    output logic drive_out,
    output logic [7:0] data_out,
    output logic [15:0] addr_out
);
    logic [7:0] low_latch = 8'h00;
    logic [7:0] dmem [int];
    // latch low byte as the strobe falls
    always @(negedge ale_in) low_latch = port_in;
    // upper byte straight from its own port
    assign addr_out = {high_in, low_latch};
    // shared port driven only under a strobe
    assign drive_out = !fetch_n_in || !rd_n_in;
    // code and data are separate stores
    always @* begin
        if (!fetch_n_in) data_out = (addr_out[7:0] ^ addr_out[15:8]) + 8'h3C;
        else if (dmem.exists(addr_out)) data_out = dmem[addr_out];
        else data_out = addr_out[7:0] ^ 8'hA5;
    end
    // write data taken as the strobe ends
    always @(posedge wr_n_in) if ($time > 0) dmem[addr_out] = port_in;
endmodule

// *** verif/external_memory_bus_interface_bench.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %0t %0h %0h", $time, g, e); end end
module external_memory_bus_interface_bench;
    import ext_bus_pkg::*;
    logic clk, arst_n, force_n, ready, oe, ale, program_fetch_strobe_n_n, wr_n, rd_n;
    logic mem_drv, program_fetch_strobe_n_seen, ale_oe, program_fetch_strobe_n_oe;
    logic [7:0] pin, last, dout, high, mem_d;
    logic [15:0] seen, strobe_addr;
    logic [31:0] r;
    bus_req_t req;
    bus_rsp_t rsp;
    int error_cnt, check_count;
    logic [7:0] exp_mem [int];

    always #(OSC_PERIOD_NS / 2) clk = ~clk;
    // A released port never shows its last value
    assign pin = oe ? dout : (mem_drv ? mem_d : ~last);
    always @(posedge clk) last <= pin;
    // Address as the memory sees it while its strobe is low
    always @(negedge clk) begin
        if (!program_fetch_strobe_n_n) program_fetch_strobe_n_seen = 1'b1;
        if (!program_fetch_strobe_n_n || !rd_n || !wr_n) strobe_addr = seen;
    end

    external_memory_bus_interface dut (
        .core_clk_in(clk), .arst_n_in(arst_n), .req_in(req),
        .req_ready_out(ready), .rsp_out(rsp),
        .external_fetch_force_n_in(force_n),
        .low_addr_data_port_in(pin), .low_addr_data_port_out(dout),
        .low_addr_data_port_oe_out(oe), .high_addr_port_out(high),
        .addr_latch_strobe_out(ale), .addr_latch_strobe_oe_out(ale_oe),
        .program_fetch_strobe_n_out(program_fetch_strobe_n_n),
        .program_fetch_strobe_n_oe_out(program_fetch_strobe_n_oe),
        .data_write_strobe_n_out(wr_n), .data_read_strobe_n_out(rd_n));

    ext_mem_model mem (
        .ale_in(ale), .port_in(pin), .high_in(high), .fetch_n_in(program_fetch_strobe_n_n),
        .rd_n_in(rd_n), .wr_n_in(wr_n), .drive_out(mem_drv),
        .data_out(mem_d), .addr_out(seen));

    task automatic conclude();
        if (error_cnt == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic run(input logic [1:0] k, input logic [15:0] a,
                       input logic [7:0] d);
        int n;
        logic ext;
        logic [7:0] e;
        ext = !(force_n && a <= INT_ROM_TOP && k < 2'h2);
        e = exp_mem.exists(a) ? exp_mem[a] : a[7:0] ^ 8'hA5;
        @(posedge clk);
        #1;
        program_fetch_strobe_n_seen = 1'b0;
        strobe_addr = ~a;
        req = '{1'b1, acc_kind_t'(k), a, d};
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ready !== 1'b1 && n < 20);
        @(posedge clk);
        #1 req.valid = 1'b0;
        n = 0;
        while (rsp.done !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        `CHK(rsp.done, 1'b1)
        `CHK(rsp.internal, !ext)
        `CHK(program_fetch_strobe_n_seen, ext && k < 2'h2)
        `CHK(ale_oe, 1'b1)
        `CHK(program_fetch_strobe_n_oe, 1'b1)
        if (ext) `CHK(strobe_addr, a)
        if (k == 2'h3) exp_mem[a] = d;
        else if (k == 2'h2) `CHK(rsp.rdata, e)
        else if (ext) `CHK(rsp.rdata, (a[7:0] ^ a[15:8]) + 8'h3C)
    endtask

    initial begin
        #(OSC_PERIOD_NS * 8000);
        error_cnt++;
        conclude();
    end

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        force_n = 1'b0;
        req = '0;
        last = 8'h00;
        error_cnt = 0;
        check_count = 0;
        void'($urandom(32'h5DF01A46));
        repeat (10) @(posedge clk);
        #1;
        `CHK(high, PORT_RESET)
        `CHK(dout, PORT_RESET)
        `CHK({oe, rsp.done, ready}, 3'h0)
        `CHK(ale_oe, 1'b0)
        `CHK(program_fetch_strobe_n_oe, 1'b0)
        repeat (10) @(posedge clk);
        #1 arst_n = 1'b1;
        // Data addresses fold onto a few bytes so reads meet writes
        for (int i = 0; i < 150; i++) begin
            r = $urandom;
            @(posedge clk);
            #1 force_n = r[20];
            repeat (2) @(posedge clk);
            run(r[17:16], r[17] ? {r[4] ? 12'hFFF : 12'h5C3, r[3:0]}
                : {r[25] ? 4'h0 : r[29:26], r[11:0]}, r[15:8]);
        end
        run(2'h3, 16'h5C30, 8'h5A);
        run(2'h0, 16'h5C30, 8'h00);
        run(2'h2, 16'h5C30, 8'h00);
        conclude();
    end
endmodule
